/* sesrc_ctrl.sv */
// Serial EEPROM command logic: status write, protection, array read and page write.
// Assumes SPI mode 0 pins from another clock domain and an APB master on pclk.
//
// Functional notes
// - Status write needs the enable latch set by a prior enable command.
// - Status write is opcode plus one byte; deselect right after its eighth bit.
// - Accepted status write starts a self-timed program cycle on deselect.
// - Status stays readable while busy; busy reads 1 during, 0 after.
// - Enable latch clears when the status write cycle ends.
// - New lock and protect bits apply only after the full cycle.
// - Status write leaves bits 6,5,4,1,0; bits 6 to 4 read zero.
// - With lock bit 0, status writes allowed whatever the protect pin.
// - Lock bit 1 and protect pin low reject status writes.
// - Hardware protect mode is lock and pin low; only pin high leaves it; a status write cycle begun earlier also clears lock at its end.
// - Array read loads the shifted address then shifts out that byte.
// - Read address increments per byte and wraps from top to zero.
// - Deselect ends an array read at any point.
// - Array read is ignored while a write cycle runs.
// - Array write ended on byte boundary starts a program cycle.
// - Further write bytes wrap within the page, one cycle.
// - Array write discarded without latch, while busy, or off boundary.
// - Array write to a protected page is discarded.
// - Program cycle erases addressed bytes to zero, then programs them.
// - Protect bits: none, top quarter, top half, whole array.
// - Latch set by enable command only; cleared by disable or completion.
//
// The APB slave port and the register offsets were left to the implementer.
`timescale 1ns/1ns
module sesrc_ctrl #(
  parameter int PROGRAM_TIME_NS = sesrc_pkg::PROGRAM_TIME_NS
) (
  // System
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Serial pins
  input  wire logic        device_enable_low,
  input  wire logic        serial_clk,
  input  wire logic        serial_in,
  input  wire logic        protect_pin_n,
  output logic             serial_out,
  output logic             serial_out_en
);

  localparam int AW = sesrc_pkg::ADDR_W;
  localparam int PW = sesrc_pkg::PAGE_W;
  localparam int PROG_CYCLES_RAW =
    (PROGRAM_TIME_NS + sesrc_pkg::CLK_PERIOD_NS - 1) / sesrc_pkg::CLK_PERIOD_NS;
  localparam int PROG_CYCLES = (PROG_CYCLES_RAW < 1) ? 1 : PROG_CYCLES_RAW;

  // Pin synchronisers; the third stage only feeds edge detection.
  logic cs_s1, cs_s2, cs_s3;
  logic sck_s1, sck_s2, sck_s3;
  logic din_s1, din_s2;
  logic wp_s1, wp_s2;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {cs_s1, cs_s2, cs_s3}    <= 3'h7;
      {sck_s1, sck_s2, sck_s3} <= 3'h0;
      {din_s1, din_s2}         <= 2'h0;
      {wp_s1, wp_s2}           <= 2'h3;
    end else begin
      {cs_s1, cs_s2, cs_s3}    <= {device_enable_low, cs_s1, cs_s2};
      {sck_s1, sck_s2, sck_s3} <= {serial_clk, sck_s1, sck_s2};
      {din_s1, din_s2}         <= {serial_in, din_s1};
      {wp_s1, wp_s2}           <= {protect_pin_n, wp_s1};
    end
  end

  wire selected = ~cs_s2;
  wire cs_rise  = cs_s2 & ~cs_s3;
  wire sck_rise = sck_s2 & ~sck_s3 & selected;
  wire sck_fall = ~sck_s2 & sck_s3 & selected;

  sesrc_pkg::sesrc_state_e state;
  logic [2:0]    bit_cnt;
  logic [7:0]    in_sh;
  logic [7:0]    opcode;
  logic          addr_phase;
  logic [7:0]    addr_hi;
  logic [AW-1:0] addr;
  logic [AW-PW-1:0] wr_page;
  logic [7:0]    page_buf [sesrc_pkg::PAGE_SIZE];
  logic [sesrc_pkg::PAGE_SIZE-1:0] wr_mask;
  logic          wr_any;
  logic [7:0]    mem [2**AW];
  logic          lock, bp_hi, bp_lo, enable_latch, busy, cyc_status;
  logic [2:0]    sr_pend;
  logic [31:0]   timer;
  logic [7:0]    out_sh;
  logic [2:0]    out_cnt;
  logic [AW-1:0] view_addr;

  wire [7:0]  next_byte = {in_sh[6:0], din_s2};
  wire        byte_done = sck_rise & (bit_cnt == 3'h7);
  wire [15:0] addr16    = {addr_hi, next_byte};
  wire [AW-1:0] addr_load_val = addr16[AW-1:0];
  wire        rd_status = (opcode == sesrc_pkg::OP_RDSTAT);

  wire hardware_protect_mode = lock & ~wp_s2;

  wire [7:0] status_byte = {lock, 3'h0, bp_hi, bp_lo, enable_latch, busy};

  wire sr_ok = enable_latch & ~busy & ~hardware_protect_mode;
  wire wr_ok = enable_latch & ~busy;

  wire [6:0] cmd_next =
    (next_byte == sesrc_pkg::OP_READ)   ? (busy ? sesrc_pkg::ST_WAIT : sesrc_pkg::ST_ADDR) :
    (next_byte == sesrc_pkg::OP_WRITE)  ? (wr_ok ? sesrc_pkg::ST_ADDR : sesrc_pkg::ST_WAIT) :
    (next_byte == sesrc_pkg::OP_WRSTAT) ? (sr_ok ? sesrc_pkg::ST_SR : sesrc_pkg::ST_WAIT) :
    (next_byte == sesrc_pkg::OP_RDSTAT) ? sesrc_pkg::ST_RD : sesrc_pkg::ST_WAIT;

  wire load_addr = byte_done & (state == sesrc_pkg::ST_ADDR) & addr_phase;
  wire rd_load   = (load_addr & (opcode == sesrc_pkg::OP_READ)) |
                   (byte_done & (state == sesrc_pkg::ST_CMD) &
                    (next_byte == sesrc_pkg::OP_RDSTAT));
  wire rd_inc    = (state == sesrc_pkg::ST_RD) & ~rd_status & sck_fall & (out_cnt == 3'h7);
  wire wr_byte   = byte_done & (state == sesrc_pkg::ST_WR);

  wire [AW-1:0] page_base = {wr_page, {PW{1'b0}}};
  wire page_prot = (bp_hi & bp_lo) |
                   (~bp_hi & bp_lo & (page_base >= sesrc_pkg::QUARTER_BASE)) |
                   (bp_hi & ~bp_lo & (page_base >= sesrc_pkg::HALF_BASE));

  wire wr_commit = cs_rise & (state == sesrc_pkg::ST_WR) & (bit_cnt == 3'h0) &
                   wr_any & ~page_prot;
  wire sr_commit = cs_rise & (state == sesrc_pkg::ST_SRD);
  wire cyc_start = wr_commit | sr_commit;
  wire cyc_end   = busy & (timer == 32'h0);

  // Input shifter; deselect restarts byte framing.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_cnt <= 3'h0;
      in_sh   <= 8'h00;
    end else if (!selected) begin
      bit_cnt <= 3'h0;
    end else if (sck_rise) begin
      bit_cnt <= bit_cnt + 3'h1;
      in_sh   <= next_byte;
    end
  end

  // extra clock in done state cancels
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= sesrc_pkg::ST_CMD;
    end else if (!selected) begin
      state <= sesrc_pkg::ST_CMD;
    end else if (sck_rise) begin
      case (state)
        sesrc_pkg::ST_CMD:  if (bit_cnt == 3'h7) state <= sesrc_pkg::sesrc_state_e'(cmd_next);
        sesrc_pkg::ST_ADDR: if (load_addr) begin
          state <= (opcode == sesrc_pkg::OP_READ) ? sesrc_pkg::ST_RD : sesrc_pkg::ST_WR;
        end
        sesrc_pkg::ST_SR:   if (bit_cnt == 3'h7) state <= sesrc_pkg::ST_SRD;
        sesrc_pkg::ST_SRD:  state <= sesrc_pkg::ST_WAIT;
        default:            state <= state;
      endcase
    end
  end

  // Command and address capture.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opcode     <= 8'h00;
      addr_phase <= 1'b0;
      addr_hi    <= 8'h00;
    end else if (!selected) begin
      addr_phase <= 1'b0;
    end else if (byte_done && state == sesrc_pkg::ST_CMD) begin
      opcode <= next_byte;
    end else if (byte_done && state == sesrc_pkg::ST_ADDR) begin
      addr_phase <= 1'b1;
      addr_hi    <= next_byte;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr    <= '0;
      wr_page <= '0;
    end else if (load_addr) begin
      addr    <= addr_load_val;
      wr_page <= addr_load_val[AW-1:PW];
    end else if (rd_inc) begin
      addr <= addr + 1'b1;
    end else if (wr_byte) begin
      addr[PW-1:0] <= addr[PW-1:0] + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_mask <= '0;
      wr_any  <= 1'b0;
      for (int i = 0; i < sesrc_pkg::PAGE_SIZE; i++) page_buf[i] <= 8'h00;
    end else if (load_addr) begin
      wr_mask <= '0;
      wr_any  <= 1'b0;
    end else if (wr_byte) begin
      page_buf[addr[PW-1:0]] <= next_byte;
      wr_mask[addr[PW-1:0]]  <= 1'b1;
      wr_any                 <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy       <= 1'b0;
      timer      <= 32'h0;
      cyc_status <= 1'b0;
    end else if (cyc_start) begin
      busy       <= 1'b1;
      timer      <= 32'(PROG_CYCLES - 1);
      cyc_status <= sr_commit;
    end else if (cyc_end) begin
      busy <= 1'b0;
    end else if (busy) begin
      timer <= timer - 32'h1;
    end
  end

  // erase at start, program at end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 2**AW; i++) mem[i] <= sesrc_pkg::BLANK_BYTE;
    end else begin
      for (int i = 0; i < sesrc_pkg::PAGE_SIZE; i++) begin
        if (wr_mask[i] && wr_commit) begin
          mem[{wr_page, PW'(i)}] <= sesrc_pkg::ERASED_BYTE;
        end else if (wr_mask[i] && cyc_end && !cyc_status) begin
          mem[{wr_page, PW'(i)}] <= page_buf[i];
        end
      end
    end
  end

  // status bits apply at cycle end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock    <= sesrc_pkg::LOCK_RESET;
      {bp_hi, bp_lo} <= sesrc_pkg::BP_RESET;
      sr_pend <= 3'h0;
    end else if (byte_done && state == sesrc_pkg::ST_SR) begin
      sr_pend <= {next_byte[sesrc_pkg::LOCK_BIT], next_byte[sesrc_pkg::BPHI_BIT],
                  next_byte[sesrc_pkg::BPLO_BIT]};
    end else if (cyc_end && cyc_status) begin
      {lock, bp_hi, bp_lo} <= sr_pend;
    end
  end

  // enable latch; a new enable wins over a finishing cycle.
  wire wait_cs  = cs_rise & (state == sesrc_pkg::ST_WAIT);
  wire latch_on = wait_cs & (opcode == sesrc_pkg::OP_ENABLE);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_latch <= 1'b0;
    end else if (latch_on) begin
      enable_latch <= 1'b1;
    end else if (cyc_end || (wait_cs && opcode == sesrc_pkg::OP_DISABLE)) begin
      enable_latch <= 1'b0;
    end
  end

  // read shifter, mode 0: drive on falling edges.
  // The opcode register still holds the previous command when a status read loads.
  wire [7:0] rd_first  = (state == sesrc_pkg::ST_CMD) ? status_byte : mem[addr_load_val];
  wire [7:0] rd_reload = rd_status ? status_byte : mem[addr + 1'b1];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_sh        <= 8'h00;
      out_cnt       <= 3'h0;
      serial_out    <= 1'b0;
      serial_out_en <= 1'b0;
    end else begin
      serial_out_en <= selected & (state == sesrc_pkg::ST_RD);
      if (rd_load) begin
        out_sh  <= rd_first;
        out_cnt <= 3'h0;
      end else if (state == sesrc_pkg::ST_RD && sck_fall) begin
        serial_out <= out_sh[7];
        out_sh     <= (out_cnt == 3'h7) ? rd_reload : {out_sh[6:0], 1'b0};
        out_cnt    <= out_cnt + 3'h1;
      end
    end
  end

  // APB slave: zero wait, data registered in the setup phase.
  wire hit_stat  = (paddr == sesrc_pkg::REG_STATUS);
  wire hit_vaddr = (paddr == sesrc_pkg::REG_VIEW_ADDR);
  wire hit_vdata = (paddr == sesrc_pkg::REG_VIEW_DATA);
  wire hit_any   = hit_stat | hit_vaddr | hit_vdata;
  wire [31:0] rd_mux = hit_stat  ? {23'h0, hardware_protect_mode, status_byte} :
                       hit_vaddr ? {{(32-AW){1'b0}}, view_addr} :
                       hit_vdata ? {24'h0, mem[view_addr]} : 32'h0;
  wire apb_setup = psel & ~penable;
  wire apb_wr    = psel & penable & pwrite & hit_vaddr;

  assign pready = 1'b1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata    <= 32'h0;
      pslverr   <= 1'b0;
      view_addr <= '0;
    end else begin
      if (apb_setup) begin
        prdata  <= pwrite ? 32'h0 : rd_mux;
        pslverr <= ~hit_any | (pwrite & ~hit_vaddr);
      end
      if (apb_wr) view_addr <= pwdata[AW-1:0];
    end
  end

  // Checks.
  logic [31:0] busy_cnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) busy_cnt <= 32'h0;
    else if (cyc_start) busy_cnt <= 32'h1;
    else if (busy) busy_cnt <= busy_cnt + 32'h1;
  end

  default clocking dcb @(posedge pclk); endclocking
  default disable iff (!presetn);

  cycle_length_a: assert property (cyc_end |-> busy_cnt == PROG_CYCLES)
    else $error("Program cycle length wrong.");
  latch_clear_a: assert property ($fell(busy) && !$past(latch_on) |-> !enable_latch)
    else $error("Enable latch not cleared at cycle end.");
  status_hold_a: assert property (busy && cyc_status && !cyc_end |=>
      $stable({lock, bp_hi, bp_lo}))
    else $error("Status bits changed during cycle.");
  busy_visible_a: assert property (cyc_start |=> busy ##0 rd_mux[0] || !hit_stat)
    else $error("Busy not visible after start.");
  hpm_reject_a: assert property (byte_done && state == sesrc_pkg::ST_CMD &&
      next_byte == sesrc_pkg::OP_WRSTAT && hardware_protect_mode |=> state == sesrc_pkg::ST_WAIT)
    else $error("Status write accepted in hardware protect mode.");
  hpm_exit_a: assert property (hardware_protect_mode && !busy |=>
      hardware_protect_mode || wp_s2)
    else $error("Hardware protect left without pin high.");
  read_busy_a: assert property (byte_done && state == sesrc_pkg::ST_CMD &&
      next_byte == sesrc_pkg::OP_READ && busy |=> state == sesrc_pkg::ST_WAIT)
    else $error("Read accepted while busy.");
  write_gate_a: assert property (byte_done && state == sesrc_pkg::ST_CMD &&
      next_byte == sesrc_pkg::OP_WRITE && !enable_latch |=> state == sesrc_pkg::ST_WAIT)
    else $error("Write accepted without enable latch.");
  read_wrap_a: assert property (rd_inc && !load_addr |=> addr == $past(addr) + 1'b1)
    else $error("Read address did not advance.");
  prot_block_a: assert property (cs_rise && state == sesrc_pkg::ST_WR && page_prot
      && !busy |=> !busy)
    else $error("Protected page write started a cycle.");
  erase_a: assert property (wr_commit && wr_mask[0] |=>
      mem[{wr_page, PW'(0)}] == sesrc_pkg::ERASED_BYTE)
    else $error("Addressed byte not erased.");

  status_write_c: cover property (sr_commit ##1 busy);
  array_write_c:  cover property (wr_commit ##1 busy);
  read_wrap_c:    cover property (rd_inc && addr == {AW{1'b1}});
  hpm_enter_c:    cover property ($rose(hardware_protect_mode));

endmodule

/* sesrc_pkg.sv */
// Package for the serial EEPROM command block: opcodes, status layout,
// register offsets, reset values and timing.
// Assumes a 250 MHz system clock and a 32-bit APB bus.
package sesrc_pkg;

  localparam int ADDR_W    = 10;
  localparam int PAGE_W    = 5;
  localparam int PAGE_SIZE = 32;

  // Serial command opcodes.
  localparam logic [7:0] OP_ENABLE  = 8'h06;
  localparam logic [7:0] OP_DISABLE = 8'h04;
  localparam logic [7:0] OP_RDSTAT  = 8'h05;
  localparam logic [7:0] OP_WRSTAT  = 8'h01;
  localparam logic [7:0] OP_READ    = 8'h03;
  localparam logic [7:0] OP_WRITE   = 8'h02;

  // Status byte field positions.
  localparam int LOCK_BIT  = 7;
  localparam int BPHI_BIT  = 3;
  localparam int BPLO_BIT  = 2;
  localparam int LATCH_BIT = 1;
  localparam int BUSY_BIT  = 0;

  // Protected region bases.
  localparam logic [ADDR_W-1:0] QUARTER_BASE = 10'h300;
  localparam logic [ADDR_W-1:0] HALF_BASE    = 10'h200;

  // Erase value and values after reset.
  localparam logic [7:0] ERASED_BYTE = 8'h00;
  localparam logic [7:0] BLANK_BYTE  = 8'hff;
  localparam logic       LOCK_RESET  = 1'b0;
  localparam logic [1:0] BP_RESET    = 2'h0;

  // Timing.
  localparam int CLK_PERIOD_NS   = 4;
  localparam int PROGRAM_TIME_NS = 1000000;

  // APB register byte offsets.
  localparam logic [11:0] REG_STATUS    = 12'h000;
  localparam logic [11:0] REG_VIEW_ADDR = 12'h004;
  localparam logic [11:0] REG_VIEW_DATA = 12'h008;

  typedef enum logic [6:0] {
    ST_CMD  = 7'h01,
    ST_ADDR = 7'h02,
    ST_RD   = 7'h04,
    ST_WR   = 7'h08,
    ST_SR   = 7'h10,
    ST_SRD  = 7'h20,
    ST_WAIT = 7'h40
  } sesrc_state_e;

endpackage

/* sesrc_host.sv */
// Host side model of the serial link: select, mode 0 clock and data.
// Assumes a free pclk; tasks are called from the bench by hierarchy.
`timescale 1ns/1ns
module sesrc_host (
  // System
  input  wire logic pclk,
  // From device
  input  wire logic miso,
  input  wire logic miso_en,
  // To device
  output logic      cs_n,
  output logic      sclk,
  output logic      mosi
);
  logic [7:0] tx [0:7];
  logic [7:0] rx [0:7];
  logic       en_seen;

  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    mosi = 1'b0;
    en_seen = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // Sends n whole bytes then k loose bits; the clock rests low outside frames.
  task automatic frame(input int n, input int k);
    int i;
    int b;
    en_seen = 1'b0;
    @(posedge pclk);
    cs_n <= 1'b0;
    tick(4);
    for (i = 0; i < n + (k > 0 ? 1 : 0); i++) begin
      for (b = 7; b >= 0 && (i < n || b > 7 - k); b--) begin
        mosi <= tx[i][b];
        tick(4);
        sclk <= 1'b1;
        tick(4);
        // A released output line is seen as the inverse of its last level.
        rx[i][b] = miso_en ? miso : ~miso;
        en_seen = en_seen | miso_en;
        sclk <= 1'b0;
      end
    end
    tick(4);
    cs_n <= 1'b1;
    mosi <= ~mosi;
    tick(5);
  endtask
endmodule

/* tb.sv */
// Self-checking bench for the serial EEPROM command block.
// Assumes the host model drives the link and APB reaches the status view.
`timescale 1ns/1ns
module tb;
  logic        pclk, presetn, psel, penable, pwrite, protect_pin_n;
  logic        pready, pslverr, err, cs_n, sclk, mosi, miso, miso_en;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, seed;
  logic [7:0]  d [0:3];
  logic [9:0]  a;
  logic [9:0]  pb [0:3];
  logic        pr;
  int          failures, samples_checked, cyc, c, j;

  sesrc_ctrl #(.PROGRAM_TIME_NS(4000)) dut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .device_enable_low(cs_n),
    .serial_clk(sclk), .serial_in(mosi), .protect_pin_n(protect_pin_n),
    .serial_out(miso), .serial_out_en(miso_en));
  sesrc_host host (.pclk(pclk), .miso(miso), .miso_en(miso_en),
    .cs_n(cs_n), .sclk(sclk), .mosi(mosi));

  always #2 pclk = ~pclk;

  // A hung handshake would stall forever, so the run is capped.
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      failures++;
      results();
    end
  end

  task automatic results();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic stat(input logic [8:0] m, input logic [8:0] e);
    apb(1'b0, sesrc_pkg::REG_STATUS, 32'h0);
    chk("status", {23'h0, e}, {23'h0, rd[8:0] & m});
  endtask

  task automatic view(input logic [9:0] ad);
    apb(1'b1, sesrc_pkg::REG_VIEW_ADDR, {22'h0, ad});
    apb(1'b0, sesrc_pkg::REG_VIEW_DATA, 32'h0);
  endtask

  task automatic sfr(input logic [7:0] op, input logic [7:0] v, input int n, input int k);
    host.tx[0] = op;
    host.tx[1] = v;
    host.frame(n, k);
  endtask

  task automatic send(input logic [7:0] op, input logic [9:0] ad, input int n, input int k);
    int i;
    host.tx[0] = op;
    host.tx[1] = {6'h0, ad[9:8]};
    host.tx[2] = ad[7:0];
    for (i = 0; i < 4; i++) host.tx[3 + i] = d[i];
    host.frame(3 + n, k);
  endtask

  task automatic idle();
    int n;
    n = 0;
    do begin
      apb(1'b0, sesrc_pkg::REG_STATUS, 32'h0);
      n++;
    end while (rd[0] !== 1'b0 && n < 500);
    chk("idle", 32'h0, {31'h0, rd[0]});
  endtask

  // Next state of the stimulus shift register.
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Whether an address lies in the area guarded by a given protect setting.
  function automatic logic prot(input int bp, input logic [9:0] ad);
    return (bp == 3) || (bp == 1 && ad >= sesrc_pkg::QUARTER_BASE) ||
           (bp == 2 && ad >= sesrc_pkg::HALF_BASE);
  endfunction

  task automatic rnd();
    int i;
    for (i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      d[i] = seed[7:0];
    end
  endtask

  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0;
    pwdata = 0; protect_pin_n = 1; failures = 0; samples_checked = 0; cyc = 0;
    seed = 32'ha602;
    pb[0] = 10'h000; pb[1] = 10'h300; pb[2] = 10'h200; pb[3] = 10'h000;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    stat(9'h1ff, 9'h000);
    apb(1'b0, 12'h00c, 32'h0); chk("unmapped", 1, err);
    apb(1'b1, sesrc_pkg::REG_STATUS, 32'hff); chk("ro write", 1, err);
    rnd(); send(sesrc_pkg::OP_WRITE, 10'h01e, 4, 0);
    stat(9'h1ff, 9'h000);
    sfr(sesrc_pkg::OP_ENABLE, 8'h0, 1, 0);
    sfr(sesrc_pkg::OP_RDSTAT, 8'h0, 2, 0); chk("spi st", 8'h02, host.rx[1]);
    send(sesrc_pkg::OP_WRITE, 10'h01e, 4, 0);
    sfr(sesrc_pkg::OP_RDSTAT, 8'h0, 2, 0); chk("spi st", 8'h03, host.rx[1]);
    view(10'h000); chk("erased", 32'h0, rd);
    send(sesrc_pkg::OP_READ, 10'h000, 1, 0); chk("rd busy", 0, host.en_seen);
    send(sesrc_pkg::OP_WRITE, 10'h040, 1, 0);
    idle(); stat(9'h1ff, 9'h000);
    send(sesrc_pkg::OP_READ, 10'h3ff, 3, 0);
    chk("rd top", 8'hff, host.rx[3]);
    chk("rd wrap", d[2], host.rx[4]);
    chk("rd next", d[3], host.rx[5]);
    view(10'h01e); chk("page", d[0], rd);
    view(10'h040); chk("busy wr", 8'hff, rd);
    sfr(sesrc_pkg::OP_ENABLE, 8'h0, 1, 0);
    send(sesrc_pkg::OP_WRITE, 10'h050, 1, 3); stat(9'h1ff, 9'h002);
    send(sesrc_pkg::OP_READ, 10'h000, 0, 5); stat(9'h1ff, 9'h002);
    sfr(sesrc_pkg::OP_WRSTAT, 8'hff, 2, 0);
    sfr(sesrc_pkg::OP_RDSTAT, 8'h0, 2, 0); chk("spi st", 8'h03, host.rx[1]);
    idle(); stat(9'h1ff, 9'h08c);
    sfr(sesrc_pkg::OP_ENABLE, 8'h0, 1, 0);
    sfr(sesrc_pkg::OP_WRSTAT, 8'h00, 2, 1); stat(9'h1fd, 9'h08c);
    protect_pin_n <= 1'b0; repeat (4) @(posedge pclk);
    stat(9'h1fd, 9'h18c);
    sfr(sesrc_pkg::OP_WRSTAT, 8'h00, 2, 0); stat(9'h1fd, 9'h18c);
    protect_pin_n <= 1'b1; repeat (4) @(posedge pclk);
    stat(9'h1fd, 9'h08c);
    sfr(sesrc_pkg::OP_ENABLE, 8'h0, 1, 0);
    sfr(sesrc_pkg::OP_WRSTAT, 8'h00, 2, 0); idle(); stat(9'h1ff, 9'h000);
    protect_pin_n <= 1'b0;
    for (c = 0; c < 4; c++) begin
      sfr(sesrc_pkg::OP_ENABLE, 8'h0, 1, 0);
      sfr(sesrc_pkg::OP_WRSTAT, 8'(c << 2), 2, 0); idle();
      for (j = 0; j < 2; j++) begin
        a = pb[c] - 10'(j);
        pr = prot(c, a);
        rnd();
        sfr(sesrc_pkg::OP_ENABLE, 8'h0, 1, 0);
        send(sesrc_pkg::OP_WRITE, a, 1, 0);
        stat(9'h001, {8'h0, ~pr});
        idle();
        view(a);
        if (!pr) chk("prot wr", d[0], rd);
      end
    end
    results();
  end
endmodule
